// File: verilog/omc_pkg.sv
// Function
// RL1: Three global modes shared by all macrocells
// RL2: Two global bits jointly pick the mode
// RL3: Per-macrocell polarity bit in every mode
// RL4: Per-macrocell bit picks input, output or bidirectional
// RL5: Two global plus sixteen per-macrocell bits
// RL6: Configurer picks registered when any register used
// RL7: Configurer picks complex for term-enabled outputs
// RL8: Configurer picks simple only for plain outputs
// RL9: Registered: pin 1 clock, pin 13 enable
// RL10: Complex: pins 1, 13 use pin 22, 15 feedback
// RL11: Simple: feedback via adjacent pin; center none
// RL12: Complex: each macrocell output-only or bidirectional
// RL13: Complex: six bidirectional at most; outer ones output
// RL14: Complex: seven terms, one drives output enable
// RL15: Complex and simple: pins 1, 13 feed array
// RL16: Simple: dedicated input or always-enabled output
// RL17: Simple: eight terms and programmable polarity
// RL18: Simple: center macrocells never inputs
// RL19: Configurer uses registered for eight bidirectional pins
// RL20: Registered macrocells capture on pin 1 rising edge
package omc_pkg;

    localparam int OMC_NUM_MC = 8;
    localparam int OMC_NUM_PT = 8;
    localparam int OMC_NUM_DED = 12;
    localparam int OMC_ARR_W = OMC_NUM_DED + OMC_NUM_MC;
    localparam int OMC_SYNC_STAGES = 2;

    // Product term that drives the output enable in complex mode
    localparam int OMC_OE_PT = 0;
    // Macrocell index 0 sits on DIP pin 22, index 7 on DIP pin 15
    localparam int OMC_OUTER_LO = 0;
    localparam int OMC_OUTER_HI = 7;
    localparam int OMC_CENTER_LO = 3;
    localparam int OMC_CENTER_HI = 4;

    localparam logic OMC_RST_PIN = 1'h0;
    localparam logic [7:0] OMC_RST_BYTE = 8'h00;
    localparam logic [OMC_ARR_W-1:0] OMC_RST_ARR = 20'h00000;

    typedef enum logic [2:0] {
        OMC_MODE_REG = 3'b001,
        OMC_MODE_CPLX = 3'b010,
        OMC_MODE_SIMP = 3'b100
    } omc_mode_t;

    typedef struct packed {
        logic sync_select_bit;
        logic global_arch_ctrl_bit;
        logic [OMC_NUM_MC-1:0] polarity;
        logic [OMC_NUM_MC-1:0] local_arch_ctrl_bit;
    } omc_cfg_t;

    typedef struct packed {
        logic [OMC_NUM_MC-1:0] pin_o;
        logic [OMC_NUM_MC-1:0] pin_oe;
    } omc_pins_t;

endpackage

// File: verilog/omc_sync.sv
`timescale 1ns/1ps
module omc_sync
    import omc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// File: verilog/omc_top.sv
`timescale 1ns/1ps
module omc_top
    import omc_pkg::*;
#(
    parameter int NUM_MC = OMC_NUM_MC,
    parameter int NUM_PT = OMC_NUM_PT,
    parameter int NUM_DED = OMC_NUM_DED
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic CE,
    input wire omc_cfg_t CFG,
    input wire logic CLK_PIN,
    input wire logic OE_PIN_N,
    input wire logic [NUM_DED-1:0] DED_PIN,
    input wire logic [NUM_MC-1:0] MC_PIN_I,
    input wire logic [NUM_MC*NUM_PT-1:0] PTERM,
    output omc_pins_t MC_PINS,
    output logic [NUM_DED+NUM_MC-1:0] ARRAY_IN,
    output omc_mode_t MODE,
    output logic CFG_INVALID
);

    localparam int SYNC_W = NUM_DED + NUM_MC + 2;

    logic [SYNC_W-1:0] raw_pins;
    logic [SYNC_W-1:0] sync_pins;
    logic [NUM_DED-1:0] ded_s;
    logic [NUM_MC-1:0] mc_pin_s;
    logic clk_pin_s;
    logic oe_pin_n_s;
    logic clk_pin_d;
    logic clk_rise;
    logic [OMC_SYNC_STAGES-1:0] sync_fill;
    omc_mode_t next_mode;
    logic next_invalid;
    logic [NUM_MC-1:0] q;
    logic [NUM_MC-1:0] next_pin_o;
    logic [NUM_MC-1:0] next_pin_oe;
    logic [NUM_MC-1:0] fb_slot;

    // Every pin arrives from outside the clock domain
    assign raw_pins = {CLK_PIN, OE_PIN_N, DED_PIN, MC_PIN_I};

    omc_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(CORE_CLK),
        .srst(SRST),
        .ce(CE),
        .d(raw_pins),
        .q(sync_pins)
    );

    // Synchroniser lanes, lowest first: macrocell pins, dedicated pins,
    // then pin 13 and pin 1 on top
    assign mc_pin_s = sync_pins[NUM_MC-1:0];
    assign ded_s = sync_pins[NUM_DED+NUM_MC-1:NUM_MC];
    assign oe_pin_n_s = sync_pins[NUM_DED+NUM_MC];
    assign clk_pin_s = sync_pins[NUM_DED+NUM_MC+1];

    // Mode decode from the two global bits; the fourth code is not a
    // mode, so it is flagged and falls back to simple, the safest choice
    always_comb begin
        next_invalid = 1'b0;
        case ({CFG.sync_select_bit, CFG.global_arch_ctrl_bit}) // RL2
            2'b01: next_mode = OMC_MODE_REG; // RL1
            2'b11: next_mode = OMC_MODE_CPLX; // RL1
            2'b10: next_mode = OMC_MODE_SIMP; // RL1
            default: begin
                next_mode = OMC_MODE_SIMP;
                next_invalid = 1'b1;
            end
        endcase
    end

    // Mode follows the global bits one edge later; CE low holds it
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            MODE <= OMC_MODE_SIMP;
            CFG_INVALID <= OMC_RST_PIN;
        end else if (CE) begin
            MODE <= next_mode;
            CFG_INVALID <= next_invalid;
        end
    end

    // Counts edges since reset until the synchroniser holds real pin
    // samples; before that its stages show only reset zeros
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            sync_fill <= '0;
        end else if (CE) begin
            sync_fill <= {sync_fill[OMC_SYNC_STAGES-2:0], 1'b1};
        end
    end

    // Pin 1 is sampled, not used as a clock, so its edges are seen two
    // core cycles late, after both synchroniser stages, and must be slower than half of CORE_CLK.
    // The previous level starts high and waits for real samples, so a
    // pin resting high through reset gives no false rise; the cost is
    // that a rise in the first core cycles after reset is missed.
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            clk_pin_d <= ~OMC_RST_PIN;
        end else if (CE && sync_fill[OMC_SYNC_STAGES-1]) begin
            clk_pin_d <= clk_pin_s;
        end
    end

    // One-cycle pulse on each sampled low-to-high change of pin 1
    assign clk_rise = clk_pin_s & ~clk_pin_d; // RL9

    // One slice per macrocell; slice 0 sits next to pin 1 and slice 7
    // next to pin 13, which is why the outer slots can lend them a path
    genvar i;
    generate
        for (i = 0; i < NUM_MC; i++) begin : g_mc
            logic [NUM_PT-1:0] pt;
            logic sum_all;
            logic sum_logic;
            logic oe_term;
            logic inv;
            logic is_reg;
            logic center;
            logic adj_pin;

            // Term 0 doubles as the enable term in complex mode and for combinational macrocells in registered mode
            assign pt = PTERM[i*NUM_PT +: NUM_PT];
            assign sum_all = |pt;
            assign sum_logic = |(pt & ~(NUM_PT'(1) << OMC_OE_PT)); // RL14
            assign oe_term = pt[OMC_OE_PT]; // RL14
            assign inv = ~CFG.polarity[i]; // RL3
            assign is_reg = ~CFG.local_arch_ctrl_bit[i]; // RL4
            assign center = (i == OMC_CENTER_LO) || (i == OMC_CENTER_HI);

            // Registered macrocells load on each sampled rising edge
            always_ff @(posedge CORE_CLK) begin
                if (SRST) begin
                    q[i] <= OMC_RST_PIN;
                end else if (CE && clk_rise &&
                             MODE == OMC_MODE_REG && is_reg) begin
                    q[i] <= sum_all ^ inv; // RL20
                end
            end

            // Neighbour that lends its pin to this feedback slot
            if (i == OMC_OUTER_LO) begin : g_adj_lo
                assign adj_pin = clk_pin_s; // RL10 RL15
            end else if (i == OMC_OUTER_HI) begin : g_adj_hi
                assign adj_pin = oe_pin_n_s; // RL10 RL15
            end else if (i <= OMC_CENTER_LO) begin : g_adj_up
                assign adj_pin = mc_pin_s[i-1]; // RL11
            end else begin : g_adj_dn
                assign adj_pin = mc_pin_s[i+1]; // RL11
            end

            // Drive, enable and feedback slot for the selected mode
            always_comb begin
                next_pin_o[i] = 1'b0;
                next_pin_oe[i] = 1'b0;
                fb_slot[i] = 1'b0;
                case (MODE)
                    OMC_MODE_REG: begin
                        if (is_reg) begin
                            next_pin_o[i] = q[i];
                            next_pin_oe[i] = ~oe_pin_n_s; // RL9
                            fb_slot[i] = q[i];
                        end else begin
                            next_pin_o[i] = sum_logic ^ inv;
                            next_pin_oe[i] = oe_term;
                            fb_slot[i] = mc_pin_s[i];
                        end
                    end
                    OMC_MODE_CPLX: begin
                        next_pin_o[i] = sum_logic ^ inv; // RL14 RL3
                        next_pin_oe[i] = oe_term; // RL14
                        // Outer slots carry pins 1 and 13 instead
                        if (i == OMC_OUTER_LO || i == OMC_OUTER_HI) begin
                            fb_slot[i] = adj_pin; // RL10 RL13
                        end else if (!is_reg) begin
                            fb_slot[i] = mc_pin_s[i]; // RL12 RL4
                        end
                    end
                    OMC_MODE_SIMP: begin
                        if (!is_reg && !center) begin
                            next_pin_oe[i] = 1'b0; // RL16 RL4
                        end else begin
                            next_pin_o[i] = sum_all ^ inv; // RL17 RL18
                            next_pin_oe[i] = 1'b1; // RL16
                        end
                        // Center slots carry a neighbour, never themselves
                        fb_slot[i] = adj_pin; // RL11
                    end
                    default: begin
                        next_pin_oe[i] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    // Registered pin drive costs one cycle but keeps glitches off pins
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            MC_PINS.pin_o <= OMC_RST_BYTE;
            MC_PINS.pin_oe <= OMC_RST_BYTE;
        end else if (CE) begin
            MC_PINS.pin_o <= next_pin_o;
            MC_PINS.pin_oe <= next_pin_oe;
        end
    end

    // Dedicated pins sit above the eight feedback slots
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ARRAY_IN <= OMC_RST_ARR;
        end else if (CE) begin
            ARRAY_IN <= {ded_s, fb_slot}; // RL5
        end
    end

endmodule

// File: testbench/omc_asserts.sv
`timescale 1ns/1ps
module omc_asserts
    import omc_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic CE,
    input wire omc_cfg_t CFG,
    input wire logic [63:0] PTERM,
    input wire omc_pins_t MC_PINS,
    input wire omc_mode_t MODE,
    input wire logic CFG_INVALID
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    wire [1:0] gb = {CFG.sync_select_bit, CFG.global_arch_ctrl_bit};
    AST_MODE_REG: assert property (
        CE && gb == 2'h1 |=> MODE == OMC_MODE_REG)
        else $error("mode not registered");
    AST_MODE_CPLX: assert property (
        CE && gb == 2'h3 |=> MODE == OMC_MODE_CPLX)
        else $error("mode not complex");
    AST_MODE_SIMP: assert property (
        CE && !gb[0] |=> MODE == OMC_MODE_SIMP)
        else $error("mode not simple");
    // A release edge still samples reset high, and the design only starts
    // decoding on the edge after it, so attempts there are skipped
    AST_INVALID: assert property (
        !SRST && CE |=> CFG_INVALID == ($past(gb) == 2'h0))
        else $error("invalid flag wrong");
    // Pins lag the global bits by two edges and the per-macrocell bits by one, so only a settled config is judged
    AST_CENTER: assert property (
        !SRST && CE && MODE == OMC_MODE_SIMP && $stable(CFG)
        |=> MC_PINS.pin_oe[4:3] == 2'h3)
        else $error("center not driving");
    AST_SIMP_IN: assert property (
        !SRST && CE && MODE == OMC_MODE_SIMP && $stable(CFG)
        |=> MC_PINS.pin_oe[0] == !$past(CFG.local_arch_ctrl_bit[0]))
        else $error("simple direction wrong");
    AST_CPLX_OE: assert property (
        !SRST && CE && MODE == OMC_MODE_CPLX && $stable(CFG)
        |=> MC_PINS.pin_oe[7] == $past(PTERM[56]))
        else $error("enable term");
    AST_CPLX_DATA: assert property (
        !SRST && CE && MODE == OMC_MODE_CPLX && $stable(CFG)
        |=> MC_PINS.pin_o[0] ==
            ((|$past(PTERM[7:1])) ^ !$past(CFG.polarity[0])))
        else $error("complex data wrong");
    AST_SIMP_TERMS: assert property (
        !SRST && CE && MODE == OMC_MODE_SIMP && $stable(CFG)
        |=> MC_PINS.pin_o[3] ==
            ((|$past(PTERM[31:24])) ^ !$past(CFG.polarity[3])))
        else $error("simple data wrong");
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb
    import omc_pkg::*;
;
    typedef struct packed {
        logic [1:0] gb;
        logic [7:0] pol, loc, pt;
        omc_mode_t md;
        logic inv;
        logic [7:0] oe, o;
    } omc_row_t;
    logic clk = 1'h0, srst = 1'h1, ce = 1'h1, clk_pin = 1'h0, oe_n = 1'h0;
    logic [11:0] ded = 12'h000;
    logic [7:0] mci = 8'h00;
    logic [63:0] pt = 64'h0;
    omc_cfg_t cfg = '0;
    omc_pins_t pins;
    logic [19:0] arr;
    omc_mode_t mode;
    logic inval;
    int fails = 0, comparisons = 0, cyc = 0;
    omc_row_t rows [5];
    omc_top i_dut (
        .CORE_CLK(clk), .SRST(srst), .CE(ce), .CFG(cfg), .CLK_PIN(clk_pin),
        .OE_PIN_N(oe_n), .DED_PIN(ded), .MC_PIN_I(mci), .PTERM(pt),
        .MC_PINS(pins), .ARRAY_IN(arr), .MODE(mode), .CFG_INVALID(inval)
    );
    always #2.5 clk = ~clk;
    task automatic end_of_test();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Whole run is under 150 cycles; a hang is stopped at cycle 500, well above that
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        rows = '{
            '{2'h3, 8'h00, 8'h00, 8'h03, OMC_MODE_CPLX, 1'h0, 8'hff, 8'h00},
            '{2'h3, 8'h00, 8'h7e, 8'h01, OMC_MODE_CPLX, 1'h0, 8'hff, 8'hff},
            '{2'h2, 8'hff, 8'hff, 8'h01, OMC_MODE_SIMP, 1'h0, 8'h18, 8'hff},
            '{2'h0, 8'h00, 8'h00, 8'h80, OMC_MODE_SIMP, 1'h1, 8'hff, 8'h00},
            '{2'h1, 8'hff, 8'hff, 8'h03, OMC_MODE_REG, 1'h0, 8'hff, 8'hff}};
        repeat (10) @(posedge clk);
        #1;
        `CHK(mode, OMC_MODE_SIMP)
        @(posedge clk);
        srst <= 1'h0;
        foreach (rows[i]) begin
            @(posedge clk);
            cfg <= {rows[i].gb, rows[i].pol, rows[i].loc};
            pt <= {8{rows[i].pt}};
            repeat (3) @(posedge clk);
            #1;
            `CHK(mode, rows[i].md)
            `CHK(inval, rows[i].inv)
            `CHK(pins.pin_oe, rows[i].oe)
            `CHK(pins.pin_o & rows[i].oe, rows[i].o & rows[i].oe)
        end
        @(posedge clk);
        cfg <= {2'h3, 8'hff, 8'h7e};
        clk_pin <= 1'h1;
        mci <= 8'h5a;
        ded <= 12'habc;
        repeat (4) @(posedge clk);
        #1;
        `CHK(arr, 20'habc5b)
        @(posedge clk);
        cfg <= {2'h2, 8'hff, 8'hff};
        repeat (3) @(posedge clk);
        #1;
        `CHK(arr, 20'habc25)
        @(posedge clk);
        cfg <= {2'h1, 8'hff, 8'h00};
        pt <= {8{8'h01}};
        clk_pin <= 1'h0;
        repeat (4) @(posedge clk);
        #1;
        `CHK(pins, 16'h00ff)
        @(posedge clk);
        clk_pin <= 1'h1;
        repeat (4) @(posedge clk);
        #1;
        `CHK(pins, 16'hffff)
        `CHK(arr[7:0], 8'hff)
        @(posedge clk);
        oe_n <= 1'h1;
        repeat (4) @(posedge clk);
        #1;
        `CHK(pins.pin_oe, 8'h00)
        @(posedge clk);
        ce <= 1'h0;
        cfg <= {2'h3, 8'hff, 8'h00};
        repeat (3) @(posedge clk);
        #1;
        `CHK(mode, OMC_MODE_REG)
        @(posedge clk);
        ce <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(mode, OMC_MODE_CPLX)
        // Pin 1 rests high through a reset: no false rise may load
        @(posedge clk);
        srst <= 1'h1;
        cfg <= {2'h1, 8'hff, 8'h00};
        oe_n <= 1'h0;
        repeat (10) @(posedge clk);
        srst <= 1'h0;
        repeat (6) @(posedge clk);
        #1;
        `CHK(pins, 16'h00ff)
        `CHK(arr, 20'habc00)
        end_of_test();
    end
endmodule
bind omc_top omc_asserts i_chk (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .CE(CE), .CFG(CFG), .PTERM(PTERM),
    .MC_PINS(MC_PINS), .MODE(MODE), .CFG_INVALID(CFG_INVALID)
);
